// ===== design/flash_write_protection_control.sv
// Write-protection, security flags and lock register of a serial flash.
`timescale 1ns/1ps
module flash_write_protection_control #(
  parameter int unsigned BLOCKS = 2048,
  parameter int unsigned ADDR_W = 27,
  parameter bit FACTORY_OTP_LOCKED = 1'b0,
  localparam int unsigned UNITS = BLOCKS + 2 * flash_wp_pkg::EDGE_SECTORS - 2,
  localparam int unsigned UW = $clog2(UNITS)
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic si_in,
  input wire logic write_protect_n_in,
  output logic so_out,
  output logic so_oe_n_out,
  input wire logic [3:0] block_protect_field_in,
  input wire logic [ADDR_W-1:0] query_addr_in,
  output logic query_blocked_out,
  output logic otp_mode_out,
  output logic otp_write_allowed_out,
  input wire logic op_done_in,
  input wire logic op_erase_in,
  input wire logic op_fail_in,
  input wire logic erase_suspend_in,
  input wire logic erase_resume_in,
  input wire logic program_suspend_in,
  input wire logic program_resume_in,
  input wire logic [UW-1:0] unit_in,
  input wire logic spb_set_in,
  input wire logic spb_erase_in,
  input wire logic dpb_write_in,
  input wire logic dpb_all_in,
  input wire logic dpb_value_in,
  input wire logic password_ok_in,
  output logic write_enable_latch_out,
  output flash_wp_pkg::sec_flags_t security_flags_out,
  output logic [15:0] lock_reg_out,
  output logic password_mode_out
);
  // ---------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------
  if (BLOCKS < 3 || ADDR_W != $clog2(BLOCKS) + flash_wp_pkg::BLOCK_SHIFT)
  begin : g_bad_params
    $error("Block count and address width do not match.");
  end

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic [UW-1:0] unit_of(input logic [ADDR_W-1:0] a);
    int unsigned blk, sec;
    blk = int'(a[ADDR_W-1:flash_wp_pkg::BLOCK_SHIFT]);
    sec = int'(a[flash_wp_pkg::BLOCK_SHIFT-1:flash_wp_pkg::SECTOR_SHIFT]);
    if (blk == 0) begin
      unit_of = UW'(sec);
    end else if (blk == BLOCKS - 1) begin
      unit_of = UW'(BLOCKS + flash_wp_pkg::EDGE_SECTORS - 2 + sec);
    end else begin
      unit_of = UW'(blk + flash_wp_pkg::EDGE_SECTORS - 1);
    end
  endfunction : unit_of

  function automatic logic bp_protects(input logic [3:0] bp,
                                       input logic [ADDR_W-1:0] a);
    int unsigned blk, span;
    blk = int'(a[ADDR_W-1:flash_wp_pkg::BLOCK_SHIFT]);
    span = (bp == 4'h0) ? 0 : (1 << (int'(bp) - 1));
    bp_protects = (bp != 4'h0) && (span >= BLOCKS || blk >= BLOCKS - span);
  endfunction : bp_protects

  // ---------------------------------------------------------------
  // Link receiver and write-protect pin synchroniser
  // ---------------------------------------------------------------
  flash_wp_pkg::rx_evt_t evt;
  logic wp_meta_q, wp_sync_q;

  spi_frame_rx u_rx (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .cs_n_in(cs_n_in),
    .sclk_in(sclk_in),
    .si_in(si_in),
    .evt_out(evt)
  );

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      wp_meta_q <= 1'b1;
      wp_sync_q <= 1'b1;
    end else begin
      wp_meta_q <= write_protect_n_in;
      wp_sync_q <= wp_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // Command framing and register updates
  // ---------------------------------------------------------------
  flash_wp_pkg::cmd_state_t state_q, state_d;
  flash_wp_pkg::sec_flags_t sec_q, sec_d;
  logic [7:0] op_q, op_d, out_q, out_d;
  logic [2:0] len_q, len_d, obit_q, obit_d;
  logic [15:0] lock_q, lock_d, ldata_q, ldata_d, lnew;
  logic wel_q, wel_d, otp_q, otp_d, so_q, so_d, oe_n_q, oe_n_d;
  logic exec, one_byte, both_clear, spb_unlocked;

  always_comb begin
    state_d = state_q;
    sec_d = sec_q;
    op_d = op_q;
    out_d = out_q;
    len_d = len_q;
    obit_d = obit_q;
    lock_d = lock_q;
    ldata_d = ldata_q;
    wel_d = wel_q;
    otp_d = otp_q;
    so_d = so_q;
    oe_n_d = oe_n_q;
    lnew = lock_q & ldata_q;
    both_clear = ~lnew[flash_wp_pkg::LOCK_SOLID_BIT] &
                 ~lnew[flash_wp_pkg::LOCK_PASS_BIT];
    exec = evt.frame_end & evt.aligned;
    one_byte = (len_q == flash_wp_pkg::LEN_OPCODE);
    if (evt.frame_start) begin
      state_d = flash_wp_pkg::ST_IDLE;
      len_d = 3'h0;
    end
    if (evt.byte_valid) begin
      if (len_q != flash_wp_pkg::LEN_MAX) begin
        len_d = len_q + 3'h1;
      end
      case (state_q)
        flash_wp_pkg::ST_IDLE: begin
          op_d = evt.data;
          if (evt.data == flash_wp_pkg::OP_SEC_READ) begin
            state_d = flash_wp_pkg::ST_READ;
            out_d = sec_q;
            obit_d = 3'h0;
          end else if (evt.data == flash_wp_pkg::OP_LOCK_WRITE) begin
            state_d = flash_wp_pkg::ST_DATA;
          end else begin
            state_d = flash_wp_pkg::ST_SKIP;
          end
        end
        flash_wp_pkg::ST_DATA: begin
          ldata_d = {evt.data, ldata_q[15:8]};
        end
        default: begin
          state_d = state_q;
        end
      endcase
    end
    if (evt.fall && state_q == flash_wp_pkg::ST_READ) begin
      so_d = out_q[7];
      oe_n_d = 1'b0;
      obit_d = obit_q + 3'h1;
      out_d = (obit_q == flash_wp_pkg::BIT_LAST) ? sec_q
                                                 : {out_q[6:0], 1'b0};
    end
    if (evt.frame_end) begin
      state_d = flash_wp_pkg::ST_IDLE;
      oe_n_d = 1'b1;
    end
    // Flag bits owned by the array engine; a set beats a clear.
    if (op_done_in && op_erase_in) begin
      sec_d.erase_fail = op_fail_in;
    end
    if (op_done_in && !op_erase_in) begin
      sec_d.program_fail = op_fail_in;
    end
    if (erase_resume_in) begin
      sec_d.erase_suspended_flag = 1'b0;
    end
    if (erase_suspend_in) begin
      sec_d.erase_suspended_flag = 1'b1;
    end
    if (program_resume_in) begin
      sec_d.program_suspended_flag = 1'b0;
    end
    if (program_suspend_in) begin
      sec_d.program_suspended_flag = 1'b1;
    end
    if (exec && one_byte) begin
      case (op_q)
        flash_wp_pkg::OP_WRITE_ENABLE: wel_d = 1'b1;
        flash_wp_pkg::OP_WRITE_DISABLE: wel_d = 1'b0;
        flash_wp_pkg::OP_OTP_ENTER: otp_d = 1'b1;
        flash_wp_pkg::OP_OTP_EXIT: otp_d = 1'b0;
        flash_wp_pkg::OP_SCHEME_SELECT: begin
          if (wel_q) begin
            sec_d.scheme = 1'b1;
            wel_d = 1'b0;
          end
        end
        flash_wp_pkg::OP_SEC_WRITE: begin
          if (wel_q) begin
            sec_d.otp_customer_lockdown = 1'b1;
            wel_d = 1'b0;
          end
        end
        default: begin
          wel_d = wel_q;
        end
      endcase
    end
    if (exec && op_q == flash_wp_pkg::OP_LOCK_WRITE && wel_q &&
        sec_q.scheme && len_q == flash_wp_pkg::LEN_LOCK_WRITE) begin
      wel_d = 1'b0;
      if (both_clear) begin
        sec_d.program_fail = 1'b1;
      end else if (!lock_q[flash_wp_pkg::LOCK_SOLID_BIT] ||
                   !lock_q[flash_wp_pkg::LOCK_PASS_BIT]) begin
        lock_d = {lnew[15:3], lock_q[2:1], lnew[0]};
      end else begin
        lock_d = lnew;
      end
    end
    sec_d.reserved = 1'b0;
    sec_d.factory_locked = FACTORY_OTP_LOCKED;
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state_q <= flash_wp_pkg::ST_IDLE;
      sec_q <= '{factory_locked: FACTORY_OTP_LOCKED, default: 1'b0};
      op_q <= 8'h00;
      out_q <= 8'h00;
      len_q <= 3'h0;
      obit_q <= 3'h0;
      lock_q <= flash_wp_pkg::LOCK_RESET;
      ldata_q <= 16'hFFFF;
      wel_q <= 1'b0;
      otp_q <= 1'b0;
      so_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      state_q <= state_d;
      sec_q <= sec_d;
      op_q <= op_d;
      out_q <= out_d;
      len_q <= len_d;
      obit_q <= obit_d;
      lock_q <= lock_d;
      ldata_q <= ldata_d;
      wel_q <= wel_d;
      otp_q <= otp_d;
      so_q <= so_d;
      oe_n_q <= oe_n_d;
    end
  end

  // ---------------------------------------------------------------
  // Sector protect bits and the protection verdict
  // ---------------------------------------------------------------
  logic [UNITS-1:0] spb_q, spb_d, dpb_q, dpb_d;
  logic blocked_q, blocked_d;
  logic [UW-1:0] qunit;

  always_comb begin
    spb_d = spb_q;
    dpb_d = dpb_q;
    qunit = unit_of(query_addr_in);
    spb_unlocked = lock_q[flash_wp_pkg::LOCK_PASS_BIT] | password_ok_in;
    if (sec_q.scheme) begin
      if (spb_erase_in && spb_unlocked) begin
        spb_d = '0;
      end else if (spb_set_in && spb_unlocked) begin
        spb_d[unit_in] = 1'b1;
      end
      if (dpb_all_in) begin
        dpb_d = {UNITS{dpb_value_in}};
      end else if (dpb_write_in) begin
        dpb_d[unit_in] = dpb_value_in;
      end
    end
    if (otp_q) begin
      blocked_d = 1'b1;
    end else if (sec_q.scheme) begin
      blocked_d = ~wp_sync_q | spb_q[qunit] | dpb_q[qunit];
    end else begin
      blocked_d = bp_protects(block_protect_field_in, query_addr_in);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      spb_q <= '0;
      dpb_q <= '1;
      blocked_q <= 1'b1;
    end else begin
      spb_q <= spb_d;
      dpb_q <= dpb_d;
      blocked_q <= blocked_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign so_out = so_q;
  assign so_oe_n_out = oe_n_q;
  assign query_blocked_out = blocked_q;
  assign otp_mode_out = otp_q;
  assign otp_write_allowed_out = otp_q & ~sec_q.otp_customer_lockdown &
                                 ~sec_q.factory_locked;
  assign write_enable_latch_out = wel_q;
  assign security_flags_out = sec_q;
  assign lock_reg_out = lock_q;
  assign password_mode_out = ~lock_q[flash_wp_pkg::LOCK_PASS_BIT];

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  a_scheme_sticky: assert property ($past(sec_q.scheme) |-> sec_q.scheme)
    else $error("Scheme select bit fell back to zero.");
  a_lockdown_sticky: assert property (
    sec_q.otp_customer_lockdown |=> sec_q.otp_customer_lockdown)
    else $error("OTP lockdown bit was cleared.");
  a_lock_pair_safe: assert property (
    lock_q[flash_wp_pkg::LOCK_SOLID_BIT] | lock_q[flash_wp_pkg::LOCK_PASS_BIT])
    else $error("Both protection mode lock bits are cleared.");
  a_lock_abort_flag: assert property (exec && wel_q && sec_q.scheme &&
    op_q == flash_wp_pkg::OP_LOCK_WRITE && both_clear &&
    len_q == flash_wp_pkg::LEN_LOCK_WRITE
    |=> sec_q.program_fail && $stable(lock_q) && !wel_q)
    else $error("Double lock bit clear was not aborted.");
  a_wp_pin_all: assert property (sec_q.scheme && !otp_q && !wp_sync_q
    |=> query_blocked_out)
    else $error("Low write-protect pin left a unit writable.");
  a_otp_denies: assert property (otp_q |=> query_blocked_out)
    else $error("Main array reachable in OTP mode.");
  a_erase_fail_set: assert property (op_done_in && op_erase_in &&
    op_fail_in |=> sec_q.erase_fail)
    else $error("Erase failure not flagged.");
  a_program_ok_clr: assert property (op_done_in && !op_erase_in &&
    !op_fail_in && !exec |=> !sec_q.program_fail)
    else $error("Program success did not clear the flag.");
  a_suspend_flags: assert property (erase_suspend_in ##1 !erase_resume_in
    |-> sec_q.erase_suspended_flag)
    else $error("Erase suspend not shown.");
  a_reserved_zero: assert property (!sec_q.reserved && (sec_q.factory_locked
    == FACTORY_OTP_LOCKED))
    else $error("Reserved or factory bit has a wrong value.");
  a_dpb_powerup: assert property ($rose(reset_n_in) |-> &dpb_q)
    else $error("Volatile protect bits not all set after reset.");

  c_scheme_set: cover property (!sec_q.scheme ##1 sec_q.scheme);
  c_lock_solid: cover property ($fell(lock_q[flash_wp_pkg::LOCK_SOLID_BIT]));
  c_sec_read: cover property (state_q == flash_wp_pkg::ST_READ && !so_oe_n_out);
  c_wp_block: cover property (sec_q.scheme && !wp_sync_q ##1 query_blocked_out);
endmodule : flash_write_protection_control

// ===== common/flash_wp_pkg.sv
// Shared constants and types for the flash write-protection block.
package flash_wp_pkg;
  // ---------------------------------------------------------------
  // Command opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_ENABLE = 8'hA1;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'hA2;
  localparam logic [7:0] OP_SCHEME_SELECT = 8'hA3;
  localparam logic [7:0] OP_SEC_READ = 8'hA4;
  localparam logic [7:0] OP_SEC_WRITE = 8'hA5;
  localparam logic [7:0] OP_LOCK_WRITE = 8'hA6;
  localparam logic [7:0] OP_OTP_ENTER = 8'hA7;
  localparam logic [7:0] OP_OTP_EXIT = 8'hA8;
  // ---------------------------------------------------------------
  // Register layout and frame lengths
  // ---------------------------------------------------------------
  localparam int unsigned LOCK_SOLID_BIT = 1;
  localparam int unsigned LOCK_PASS_BIT = 2;
  localparam logic [15:0] LOCK_RESET = 16'hFFFF;
  localparam logic [2:0] LEN_OPCODE = 3'h1;
  localparam logic [2:0] LEN_LOCK_WRITE = 3'h3;
  localparam logic [2:0] LEN_MAX = 3'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int unsigned SECTOR_SHIFT = 12;
  localparam int unsigned BLOCK_SHIFT = 16;
  localparam int unsigned EDGE_SECTORS = 16;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic scheme;
    logic erase_fail;
    logic program_fail;
    logic reserved;
    logic erase_suspended_flag;
    logic program_suspended_flag;
    logic otp_customer_lockdown;
    logic factory_locked;
  } sec_flags_t;

  typedef struct packed {
    logic frame_start;
    logic frame_end;
    logic aligned;
    logic byte_valid;
    logic fall;
    logic [7:0] data;
  } rx_evt_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_DATA = 4'h2,
    ST_READ = 4'h4,
    ST_SKIP = 4'h8
  } cmd_state_t;
endpackage : flash_wp_pkg

// ===== design/spi_frame_rx.sv
// Pin synchroniser and serial byte receiver for the command link.
`timescale 1ns/1ps
module spi_frame_rx (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic si_in,
  output flash_wp_pkg::rx_evt_t evt_out
);
  // ---------------------------------------------------------------
  // Two-stage synchronisers and edge history
  // ---------------------------------------------------------------
  logic [2:0] meta_q, sync_q, prev_q;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  flash_wp_pkg::rx_evt_t evt_q, evt_d;
  logic rise, active;

  always_comb begin
    active = ~sync_q[2];
    rise = sync_q[1] & ~prev_q[1];
    cnt_d = cnt_q;
    shift_d = shift_q;
    evt_d = '0;
    evt_d.frame_start = prev_q[2] & ~sync_q[2];
    evt_d.frame_end = ~prev_q[2] & sync_q[2];
    evt_d.aligned = (cnt_q == 3'h0);
    evt_d.fall = active & prev_q[1] & ~sync_q[1];
    evt_d.data = shift_q;
    if (!active) begin
      cnt_d = 3'h0;
    end else if (rise) begin
      shift_d = {shift_q[6:0], sync_q[0]};
      cnt_d = cnt_q + 3'h1;
      if (cnt_q == flash_wp_pkg::BIT_LAST) begin
        evt_d.byte_valid = 1'b1;
        evt_d.data = {shift_q[6:0], sync_q[0]};
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      meta_q <= 3'h4;
      sync_q <= 3'h4;
      prev_q <= 3'h4;
      cnt_q <= 3'h0;
      shift_q <= 8'h00;
      evt_q <= '0;
    end else begin
      meta_q <= {cs_n_in, sclk_in, si_in};
      sync_q <= meta_q;
      prev_q <= sync_q;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      evt_q <= evt_d;
    end
  end

  assign evt_out = evt_q;
endmodule : spi_frame_rx

// ===== verification/spi_host_model.sv
// Host-side model of the serial command link.
`timescale 1ns/1ps
module spi_host_model (
  output logic cs_n_out,
  output logic sclk_out,
  output logic si_out,
  input wire logic so_in
);
  logic [7:0] rd;

  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    si_out = 1'b1;
    rd = 8'h00;
  end

  // ---------------------------------------------------------------
  // Frames
  // ---------------------------------------------------------------
  // Sends n bits of d MSB first; bits after the opcode are read back.
  task automatic frame(input logic [23:0] d, input int n);
    rd = 8'h00;
    cs_n_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      si_out = d[23-i];
      #62.5 sclk_out = 1'b1;
      if (i >= 8) begin
        rd = {rd[6:0], so_in};
      end
      #62.5 sclk_out = 1'b0;
    end
    #62.5 cs_n_out = 1'b1;
    si_out = ~si_out;
    #100;
  endtask : frame

  // Write commands always get their own write enable frame first.
  task automatic wr(input logic [23:0] d, input int n);
    frame({flash_wp_pkg::OP_WRITE_ENABLE, 16'h0000}, 8);
    frame(d, n);
  endtask : wr
endmodule : spi_host_model

// ===== verification/flash_write_protection_control_tb_top.sv
// Self-checking testbench for the write-protection block.
`timescale 1ns/1ps
module flash_write_protection_control_tb_top;
  localparam int unsigned BLK = 64;
  localparam int unsigned AW = 22;
  localparam int unsigned UW = $clog2(BLK + 2 * 16 - 2);
  logic clk_in, reset_n_in, cs_n, sclk, si, wp_n, so, so_oe_n;
  logic [3:0] bp;
  logic [AW-1:0] qa;
  logic qb, otp_mode, otp_wa, done, ers, fail, esus, eres, psus, pres;
  logic [UW-1:0] unit;
  logic spb_set, spb_erase, dpb_write, dpb_all, dpb_val, pw_ok;
  logic write_enable_latch, pw_mode;
  logic [15:0] lock;
  flash_wp_pkg::sec_flags_t flags;
  int n_fail = 0;
  int checked = 0;

  flash_write_protection_control #(.BLOCKS(BLK), .ADDR_W(AW),
    .FACTORY_OTP_LOCKED(1'b1)) dut_u (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .cs_n_in(cs_n), .sclk_in(sclk), .si_in(si),
    .write_protect_n_in(wp_n), .so_out(so), .so_oe_n_out(so_oe_n),
    .block_protect_field_in(bp), .query_addr_in(qa),
    .query_blocked_out(qb), .otp_mode_out(otp_mode),
    .otp_write_allowed_out(otp_wa), .op_done_in(done), .op_erase_in(ers),
    .op_fail_in(fail), .erase_suspend_in(esus), .erase_resume_in(eres),
    .program_suspend_in(psus), .program_resume_in(pres), .unit_in(unit),
    .spb_set_in(spb_set), .spb_erase_in(spb_erase),
    .dpb_write_in(dpb_write), .dpb_all_in(dpb_all),
    .dpb_value_in(dpb_val), .password_ok_in(pw_ok),
    .write_enable_latch_out(write_enable_latch), .security_flags_out(flags),
    .lock_reg_out(lock), .password_mode_out(pw_mode));

  spi_host_model host_u (.cs_n_out(cs_n), .sclk_out(sclk), .si_out(si),
    .so_in(so));

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    @(negedge clk_in);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic pulse(ref logic s);
    @(negedge clk_in) s = 1'b1;
    @(negedge clk_in) s = 1'b0;
  endtask : pulse

  task automatic op(input logic e, input logic f);
    @(negedge clk_in) ers = e;
    fail = f;
    pulse(done);
  endtask : op

  task automatic q(input logic [AW-1:0] a, input logic e);
    @(negedge clk_in) qa = a;
    @(negedge clk_in) chk({15'h0, qb}, {15'h0, e});
  endtask : q

  task automatic cmd(input logic [7:0] o);
    host_u.frame({o, 16'h0000}, 8);
  endtask : cmd

  task automatic rdf(input logic [7:0] e);
    host_u.frame({flash_wp_pkg::OP_SEC_READ, 16'h0000}, 16);
    chk({8'h00, host_u.rd}, {8'h00, e});
    chk({8'h00, flags}, {8'h00, e});
  endtask : rdf

  task automatic do_reset();
    @(negedge clk_in) reset_n_in = 1'b0;
    repeat (8) @(negedge clk_in);
    reset_n_in = 1'b1;
    repeat (3) @(negedge clk_in);
  endtask : do_reset

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk(lock, 16'hFFFF);
    chk({15'h0, write_enable_latch}, 16'h0000);
    rdf(8'h01);
    $display("test reset done");
  endtask : t_reset

  task automatic t_bp();
    @(negedge clk_in) bp = 4'h0;
    q(22'h3FFFFF, 1'b0);
    @(negedge clk_in) bp = 4'h1;
    q(22'h3FFFFF, 1'b1);
    q(22'h000000, 1'b0);
    @(negedge clk_in) bp = 4'hF;
    q(22'h000000, 1'b1);
    @(negedge clk_in) bp = 4'h0;
    cmd(flash_wp_pkg::OP_SCHEME_SELECT);
    rdf(8'h01);
    $display("test block protect done");
  endtask : t_bp

  task automatic t_scheme();
    cmd(flash_wp_pkg::OP_WRITE_ENABLE);
    chk({15'h0, write_enable_latch}, 16'h0001);
    cmd(flash_wp_pkg::OP_SCHEME_SELECT);
    chk({15'h0, write_enable_latch}, 16'h0000);
    rdf(8'h81);
    q(22'h000000, 1'b1);
    cmd(flash_wp_pkg::OP_WRITE_DISABLE);
    rdf(8'h81);
    $display("test scheme done");
  endtask : t_scheme

  task automatic t_sector();
    @(negedge clk_in) dpb_val = 1'b0;
    pulse(dpb_all);
    q(22'h000000, 1'b0);
    @(negedge clk_in) wp_n = 1'b0;
    repeat (4) @(negedge clk_in);
    q(22'h000000, 1'b1);
    wp_n = 1'b1;
    repeat (4) @(negedge clk_in);
    unit = 'h0;
    pulse(spb_set);
    q(22'h000000, 1'b1);
    q(22'h001000, 1'b0);
    @(negedge clk_in) unit = 'h1;
    dpb_val = 1'b1;
    pulse(dpb_write);
    q(22'h001000, 1'b1);
    q(22'h00F000, 1'b0);
    q(22'h010000, 1'b0);
    pulse(spb_erase);
    q(22'h000000, 1'b0);
    $display("test sector done");
  endtask : t_sector

  task automatic t_flags();
    op(1'b1, 1'b1);
    chk({8'h00, flags}, 16'h00C1);
    op(1'b0, 1'b1);
    chk({8'h00, flags}, 16'h00E1);
    op(1'b1, 1'b0);
    chk({8'h00, flags}, 16'h00A1);
    op(1'b0, 1'b0);
    chk({8'h00, flags}, 16'h0081);
    pulse(esus);
    chk({8'h00, flags}, 16'h0089);
    pulse(eres);
    pulse(psus);
    rdf(8'h85);
    pulse(pres);
    chk({8'h00, flags}, 16'h0081);
    $display("test flags done");
  endtask : t_flags

  task automatic t_lock();
    host_u.wr({flash_wp_pkg::OP_LOCK_WRITE, 16'hF9FF}, 24);
    chk(lock, 16'hFFFF);
    chk({8'h00, flags}, 16'h00A1);
    chk({15'h0, write_enable_latch}, 16'h0000);
    host_u.wr({flash_wp_pkg::OP_LOCK_WRITE, 16'hFDFF}, 24);
    chk(lock, 16'hFFFD);
    host_u.wr({flash_wp_pkg::OP_LOCK_WRITE, 16'hFBFF}, 24);
    chk(lock, 16'hFFFD);
    chk({15'h0, pw_mode}, 16'h0000);
    do_reset();
    cmd(flash_wp_pkg::OP_WRITE_ENABLE);
    cmd(flash_wp_pkg::OP_SCHEME_SELECT);
    @(negedge clk_in) pw_ok = 1'b1;
    host_u.wr({flash_wp_pkg::OP_LOCK_WRITE, 16'hFBFF}, 24);
    chk({15'h0, pw_mode}, 16'h0001);
    @(negedge clk_in) pw_ok = 1'b0;
    dpb_val = 1'b0;
    pulse(dpb_all);
    unit = 'h2;
    pulse(spb_set);
    q(22'h002000, 1'b0);
    @(negedge clk_in) pw_ok = 1'b1;
    pulse(spb_set);
    q(22'h002000, 1'b1);
    $display("test lock done");
  endtask : t_lock

  task automatic t_otp();
    cmd(flash_wp_pkg::OP_OTP_ENTER);
    chk({14'h0, otp_mode, otp_wa}, 16'h0002);
    q(22'h010000, 1'b1);
    cmd(flash_wp_pkg::OP_OTP_EXIT);
    q(22'h010000, 1'b0);
    host_u.wr({flash_wp_pkg::OP_SEC_WRITE, 16'h0000}, 8);
    chk({15'h0, write_enable_latch}, 16'h0000);
    rdf(8'h83);
    cmd(flash_wp_pkg::OP_OTP_ENTER);
    chk({14'h0, otp_mode, otp_wa}, 16'h0002);
    cmd(flash_wp_pkg::OP_OTP_EXIT);
    $display("test otp done");
  endtask : t_otp

  task automatic summarize();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  initial begin
    reset_n_in = 1'b0;
    {wp_n, bp, qa, done, ers, fail, esus, eres, psus, pres} = '0;
    wp_n = 1'b1;
    {unit, spb_set, spb_erase, dpb_write, dpb_all, dpb_val, pw_ok} = '0;
    do_reset();
    t_reset();
    t_bp();
    t_scheme();
    t_sector();
    t_flags();
    t_lock();
    t_otp();
    summarize();
  end

  initial begin
    #500000;
    n_fail++;
    summarize();
  end
endmodule : flash_write_protection_control_tb_top
